// *** src/uart_pm_pkg.sv ***
package uart_pm_pkg;

  // Register addresses on the 3-bit host address
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER = 3'h1;
  localparam logic [2:0] ADDR_ISR = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MCR = 3'h4;
  localparam logic [2:0] ADDR_LSR = 3'h5;
  localparam logic [2:0] ADDR_MSR = 3'h6;
  localparam logic [2:0] ADDR_SPR = 3'h7;

  // Key values and field positions
  localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
  localparam int LCR_DIV_BIT = 7;
  localparam int IER_SLEEP_BIT = 4;
  localparam int FCR_WAKE_BIT = 3;
  localparam int MCR_LOOP_BIT = 4;
  localparam int MCR_IR_BIT = 6;
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_DTR_BIT = 0;
  localparam int MCR_OP1_BIT = 2;
  localparam int MCR_OP2_BIT = 3;
  localparam int EFR_ENH_BIT = 4;
  localparam int FEATURE_CONTROL_SEL_BIT = 6;

  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ISR_NONE = 8'h01;

  // Identity codes; values arbitrary
  localparam logic [7:0] REVISION_CODE = 8'h01;
  localparam logic [7:0] IDENT_CODE = 8'h5a;

  // Modem inputs as a group, active low at pins
  typedef struct packed {
    logic carrier_detect_in;
    logic ring_indicate_in;
    logic data_set_ready_in;
    logic clear_to_send_in;
  } modem_in_t;

  typedef enum logic [1:0] {ST_AWAKE, ST_SLEEP, ST_SAVE} pm_state_t;

endpackage

// *** src/uart_pm_core.sv ***
// Notes on behaviour
// - Sleep needs idle, enable, quiet modem, empty FIFOs
// - Oscillator output stops while asleep
// - Wake on start edge, transmit load, modem change
// - Re-enter sleep once interrupts serviced
// - Modem status read clears change bits
// - Never enter sleep with an interrupt pending
// - Cycling continues until sleep enable cleared
// - Power-save pin plus sleep isolates host bus
// - Power-save wakes only on line or modem
// - Return to power-save after servicing
// - Leave power-save on enable or pin low
// - FIFO control bit 3 enables wake interrupt
// - Modem control bit 4 selects loopback
// - Loopback feeds transmit shifter into receiver
// - Loopback holds TX mark, outputs inactive
// - Address 0 holds receive/transmit data
// - Divisor bank at 0,1 and fraction at 2
// - Zero divisor exposes revision and identity codes
// - Address 2 interrupt status or FIFO control
// - Key value selects the enhanced bank
// - Feature bit 6 picks scratch or level
`timescale 1ns/1ps
`default_nettype none

module uart_pm_core (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Host bus, pins
  input wire logic [2:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_write_strobe_n,
  input wire logic bus_read_strobe_n,
  input wire logic chip_select_n,
  output logic [7:0] bus_rdata,
  output logic bus_rdata_oe,
  // Power control pin
  input wire logic power_save_pin,
  // Serial and modem pins
  input wire logic rx_pin,
  input wire uart_pm_pkg::modem_in_t modem_pins,
  output logic tx_pin,
  output logic request_to_send_n,
  output logic terminal_ready_n,
  output logic oscillator_output_pin,
  // UART core, same clock
  input wire logic core_tx_serial,
  input wire logic [7:0] core_rx_data,
  input wire logic [7:0] core_line_status,
  input wire logic [7:0] core_rx_level,
  input wire logic core_int_pending,
  input wire logic core_fifos_empty,
  output logic core_rx_serial,
  output logic [7:0] core_tx_data,
  output logic core_tx_load,
  output logic core_rx_pop,
  output logic asleep,
  output logic wake_irq
);
  import uart_pm_pkg::*;

  typedef struct packed {
    logic [1:0] rx_s;
    logic [1:0] ps_s;
    logic [1:0] wr_s;
    logic [1:0] rd_s;
    logic [1:0] cs_s;
    logic wr_last;
    logic rd_last;
    logic cs_last;
    logic [2:0] addr_s0;
    logic [2:0] addr_s1;
    logic [7:0] data_s0;
    logic [7:0] data_s1;
    modem_in_t mdm_s0;
    modem_in_t mdm_s1;
    modem_in_t mdm_last;
    logic rx_last;
    logic [3:0] delta;
    logic [7:0] interrupt_enable;
    logic [7:0] line_control;
    logic [7:0] modem_control;
    logic [7:0] dll;
    logic [7:0] divisor_high;
    logic [7:0] divisor_fraction;
    logic [7:0] enhanced_function;
    logic [7:0] feature_control;
    logic [7:0] scratch_pad;
    logic [7:0] enhanced_mode_select;
    logic [7:0] fifo_trigger_level;
    logic [7:0] msr_wr;
    logic [3:0][7:0] flow_char;
    logic wake_en;
    logic [7:0] fifo_control;
    pm_state_t pm;
    logic osc;
    logic [7:0] rdata;
    logic rdata_oe;
    logic [7:0] tx_data;
    logic tx_load;
    logic rx_pop;
    logic rx_ser;
    logic tx_out;
    logic rts_n;
    logic dtr_n;
    logic wirq;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic wr_edge;
  logic rd_edge;
  logic enh_bank;
  logic div_bank;
  logic div_zero;
  logic loop_on;
  logic rx_idle;
  logic start_edge;
  logic modem_change;
  logic sleep_ok;
  logic bus_isolated;
  modem_in_t mdm_eff;
  logic [7:0] msr_val;
  logic [7:0] isr_val;
  logic [7:0] rd_val;

  always_comb begin
    next_cur = cur;
    // Two-flop synchronisers for all pins
    next_cur.rx_s = {cur.rx_s[0], rx_pin};
    next_cur.ps_s = {cur.ps_s[0], power_save_pin};
    next_cur.wr_s = {cur.wr_s[0], bus_write_strobe_n};
    next_cur.rd_s = {cur.rd_s[0], bus_read_strobe_n};
    next_cur.cs_s = {cur.cs_s[0], chip_select_n};
    // Edge history taken from the second stage only, never the first
    next_cur.wr_last = cur.wr_s[1];
    next_cur.rd_last = cur.rd_s[1];
    next_cur.cs_last = cur.cs_s[1];
    next_cur.addr_s0 = bus_addr;
    next_cur.addr_s1 = cur.addr_s0;
    next_cur.data_s0 = bus_wdata;
    next_cur.data_s1 = cur.data_s0;
    next_cur.mdm_s0 = modem_pins;
    next_cur.mdm_s1 = cur.mdm_s0;

    loop_on = cur.modem_control[MCR_LOOP_BIT];
    // Loopback feeds modem outputs back, active low like pins
    mdm_eff = loop_on ? modem_in_t'({~cur.modem_control[MCR_OP2_BIT], ~cur.modem_control[MCR_OP1_BIT],
                                     ~cur.modem_control[MCR_DTR_BIT], ~cur.modem_control[MCR_RTS_BIT]})
                      : cur.mdm_s1;
    next_cur.mdm_last = mdm_eff;
    modem_change = (mdm_eff != cur.mdm_last);

    // Receive path: pin or looped transmit shifter
    next_cur.rx_ser = loop_on ? core_tx_serial : cur.rx_s[1];
    next_cur.rx_last = cur.rx_ser;
    start_edge = cur.rx_last && !cur.rx_ser;
    rx_idle = cur.modem_control[MCR_IR_BIT] ? !cur.rx_ser : cur.rx_ser;

    // Outputs inactive in loopback
    next_cur.tx_out = loop_on ? 1'b1 : core_tx_serial;
    next_cur.rts_n = loop_on ? 1'b1 : ~cur.modem_control[MCR_RTS_BIT];
    next_cur.dtr_n = loop_on ? 1'b1 : ~cur.modem_control[MCR_DTR_BIT];

    // Power-save cuts the host bus off
    bus_isolated = (cur.pm == ST_SAVE);
    rd_edge = !bus_isolated && !cur.cs_s[1] && !cur.rd_s[1];

    enh_bank = (cur.line_control == LCR_ENH_KEY);
    div_bank = cur.line_control[LCR_DIV_BIT] && !enh_bank;
    div_zero = (cur.dll == REG_RESET) && (cur.divisor_high == REG_RESET);

    // Modem status with sticky change bits; change wins over read clear
    msr_val = {~mdm_eff.carrier_detect_in, ~mdm_eff.ring_indicate_in,
               ~mdm_eff.data_set_ready_in, ~mdm_eff.clear_to_send_in, cur.delta};
    isr_val = core_int_pending ? 8'hc0 : 8'hc1;

    // Read decode
    rd_val = REG_RESET;
    unique case (cur.addr_s1)
      ADDR_DATA: begin
        if (enh_bank) rd_val = core_rx_level;
        else if (div_bank) rd_val = div_zero ? REVISION_CODE : cur.dll;
        else rd_val = core_rx_data;
      end
      ADDR_IER: begin
        if (enh_bank) rd_val = cur.feature_control;
        else if (div_bank) rd_val = div_zero ? IDENT_CODE : cur.divisor_high;
        else rd_val = cur.interrupt_enable;
      end
      ADDR_ISR: begin
        if (enh_bank) rd_val = cur.enhanced_function;
        else if (div_bank && cur.enhanced_function[EFR_ENH_BIT]) rd_val = cur.divisor_fraction;
        else rd_val = isr_val;
      end
      ADDR_LCR: rd_val = cur.line_control;
      ADDR_MCR: rd_val = enh_bank ? cur.flow_char[0] : cur.modem_control;
      ADDR_LSR: rd_val = enh_bank ? cur.flow_char[1] : core_line_status;
      ADDR_MSR: rd_val = enh_bank ? cur.flow_char[2] : msr_val;
      ADDR_SPR: begin
        if (enh_bank) rd_val = cur.flow_char[3];
        else if (cur.feature_control[FEATURE_CONTROL_SEL_BIT]) rd_val = core_rx_level;
        else rd_val = cur.scratch_pad;
      end
    endcase
    next_cur.rdata = rd_val;
    next_cur.rdata_oe = rd_edge;

    // One-shot access detection on strobe edges
    next_cur.tx_load = 1'b0;
    next_cur.rx_pop = 1'b0;
    // Write lands as the strobe returns high, while select was still low
    wr_edge = !bus_isolated && !cur.cs_last && !cur.wr_last && cur.wr_s[1];
    if (wr_edge) begin
      unique case (cur.addr_s1)
        ADDR_DATA: begin
          if (enh_bank) next_cur.fifo_trigger_level = cur.data_s1;
          else if (div_bank) next_cur.dll = cur.data_s1;
          else begin
            next_cur.tx_data = cur.data_s1;
            next_cur.tx_load = 1'b1;
          end
        end
        ADDR_IER: begin
          if (enh_bank) next_cur.feature_control = cur.data_s1;
          else if (div_bank) next_cur.divisor_high = cur.data_s1;
          else next_cur.interrupt_enable = cur.data_s1;
        end
        ADDR_ISR: begin
          if (enh_bank) next_cur.enhanced_function = cur.data_s1;
          else if (div_bank && cur.enhanced_function[EFR_ENH_BIT]) next_cur.divisor_fraction = cur.data_s1;
          else begin
            next_cur.fifo_control = cur.data_s1;
            next_cur.wake_en = cur.data_s1[FCR_WAKE_BIT];
          end
        end
        ADDR_LCR: next_cur.line_control = cur.data_s1;
        ADDR_MCR: begin
          if (enh_bank) next_cur.flow_char[0] = cur.data_s1;
          else next_cur.modem_control = cur.data_s1;
        end
        ADDR_LSR: begin
          if (enh_bank) next_cur.flow_char[1] = cur.data_s1;
        end
        ADDR_MSR: begin
          if (enh_bank) next_cur.flow_char[2] = cur.data_s1;
          else if (cur.enhanced_function[EFR_ENH_BIT]) next_cur.msr_wr = cur.data_s1;
        end
        ADDR_SPR: begin
          if (enh_bank) next_cur.flow_char[3] = cur.data_s1;
          else if (cur.feature_control[FEATURE_CONTROL_SEL_BIT]) next_cur.enhanced_mode_select = cur.data_s1;
          else next_cur.scratch_pad = cur.data_s1;
        end
      endcase
    end
    // Read pops receive data once per strobe; ADDR_MSR read clears deltas
    if (!bus_isolated && !cur.cs_last && !cur.rd_last && cur.rd_s[1] && !enh_bank &&
        !div_bank && cur.addr_s1 == ADDR_DATA)
      next_cur.rx_pop = 1'b1;
    if (!bus_isolated && !cur.cs_last && !cur.rd_last && cur.rd_s[1] && !enh_bank &&
        cur.addr_s1 == ADDR_MSR)
      next_cur.delta = 4'h0;
    if (modem_change)
      next_cur.delta = cur.delta | (mdm_eff ^ cur.mdm_last);

    // Sleep entry conditions
    sleep_ok = !core_int_pending && cur.interrupt_enable[IER_SLEEP_BIT] && (cur.delta == 4'h0) &&
               rx_idle && !div_zero && core_fifos_empty;

    next_cur.wirq = 1'b0;
    unique case (cur.pm)
      ST_AWAKE: begin
        if (sleep_ok && !next_cur.tx_load && !modem_change)
          next_cur.pm = cur.ps_s[1] ? ST_SAVE : ST_SLEEP;
      end
      ST_SLEEP: begin
        if (start_edge || next_cur.tx_load || modem_change || !sleep_ok) begin
          next_cur.pm = ST_AWAKE;
          next_cur.wirq = cur.wake_en;
        end else if (cur.ps_s[1]) next_cur.pm = ST_SAVE;
      end
      ST_SAVE: begin
        if (start_edge || modem_change) begin
          next_cur.pm = ST_AWAKE;
          next_cur.wirq = cur.wake_en;
        end else if (!cur.interrupt_enable[IER_SLEEP_BIT] || !cur.ps_s[1])
          next_cur.pm = ST_AWAKE;
      end
    endcase

    // Oscillator output stands still while asleep
    next_cur.osc = (next_cur.pm == ST_AWAKE) ? ~cur.osc : 1'b0;
  end

  // Single state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur <= '0;
      cur.rx_s <= 2'b11;
      cur.wr_s <= 2'b11;
      cur.rd_s <= 2'b11;
      cur.cs_s <= 2'b11;
      cur.wr_last <= 1'b1;
      cur.rd_last <= 1'b1;
      cur.cs_last <= 1'b1;
      cur.mdm_s0 <= '1;
      cur.mdm_s1 <= '1;
      cur.mdm_last <= '1;
      cur.rx_last <= 1'b1;
      cur.rx_ser <= 1'b1;
      cur.tx_out <= 1'b1;
      cur.rts_n <= 1'b1;
      cur.dtr_n <= 1'b1;
      cur.pm <= ST_AWAKE;
      cur.wake_en <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flops, except asleep, decoded from pm
  assign bus_rdata = cur.rdata;
  assign bus_rdata_oe = cur.rdata_oe;
  assign tx_pin = cur.tx_out;
  assign request_to_send_n = cur.rts_n;
  assign terminal_ready_n = cur.dtr_n;
  assign oscillator_output_pin = cur.osc;
  assign core_rx_serial = cur.rx_ser;
  assign core_tx_data = cur.tx_data;
  assign core_tx_load = cur.tx_load;
  assign core_rx_pop = cur.rx_pop;
  assign asleep = (cur.pm != ST_AWAKE);
  assign wake_irq = cur.wirq;

endmodule

`default_nettype wire

// *** dv/remote_uart.sv ***
`timescale 1ns/1ps
`default_nettype none

module remote_uart (
  // Clock
  input wire logic clk,
  // Line side toward the block
  output logic rx_pin,
  output uart_pm_pkg::modem_in_t modem_pins
);
  import uart_pm_pkg::*;

  // Mark idle, held through loopback too
  initial begin
    rx_pin = 1'b1;
    modem_pins = 4'hf;
  end

  // Start bit, then back to mark so no false break
  task start_bit;
    @(negedge clk);
    rx_pin = 1'b0;
    repeat (10) @(negedge clk);
    rx_pin = 1'b1;
  endtask

  // Flip one modem line
  task toggle;
    @(negedge clk);
    modem_pins.clear_to_send_in = !modem_pins.clear_to_send_in;
  endtask
endmodule

`default_nettype wire

// *** dv/uart_pm_core_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none

module uart_pm_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Watched pins
  input wire logic bus_read_strobe_n,
  input wire logic bus_rdata_oe,
  input wire logic rx_pin,
  input wire uart_pm_pkg::modem_in_t modem_pins,
  input wire logic oscillator_output_pin,
  input wire logic core_int_pending,
  input wire logic core_tx_load,
  input wire logic asleep,
  input wire logic wake_irq
);
  import uart_pm_pkg::*;

  // One domain, so defaults once
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_osc_halt;
    asleep [*2] |-> !oscillator_output_pin;
  endproperty
  a_osc_halt: assert property (p_osc_halt) else $error("clock out while asleep");

  property p_int_block;
    core_int_pending && !asleep |=> !asleep;
  endproperty
  a_int_block: assert property (p_int_block) else $error("slept with pending");

  property p_load_pulse;
    core_tx_load |=> !core_tx_load;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load not a pulse");

  property p_wake_pulse;
    wake_irq |=> !wake_irq;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake not a pulse");

  property p_oe_rise;
    $rose(bus_rdata_oe) |-> $past(!bus_read_strobe_n, 2);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive without read");

  // Strobe long idle must release the data bus
  property p_oe_fall;
    bus_read_strobe_n [*6] |-> !bus_rdata_oe;
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("drive after read");

  property p_rx_wake;
    $fell(rx_pin) && asleep |-> ##[1:5] !asleep;
  endproperty
  a_rx_wake: assert property (p_rx_wake) else $error("no wake on start");

  property p_modem_wake;
    $changed(modem_pins) && asleep |-> ##[1:5] !asleep;
  endproperty
  a_modem_wake: assert property (p_modem_wake) else $error("no modem wake");
endmodule

bind uart_pm_core uart_pm_asserts u_chk (.clk, .sys_rst, .bus_read_strobe_n, .bus_rdata_oe,
  .rx_pin, .modem_pins, .oscillator_output_pin, .core_int_pending, .core_tx_load, .asleep,
  .wake_irq);

`default_nettype wire

// *** dv/uart_sleep_loopback_regmap_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module uart_sleep_loopback_regmap_test;
  import uart_pm_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] bus_addr = 3'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic wr_n = 1'b1;
  logic rd_n = 1'b1;
  logic cs_n = 1'b1;
  logic power_save_pin = 1'b0;
  logic core_tx_serial = 1'b1;
  logic core_int_pending = 1'b0;
  logic core_fifos_empty = 1'b1;
  logic [7:0] bus_rdata, core_tx_data;
  logic bus_rdata_oe, tx_pin, rts_n, dtr_n, osc, core_rx_serial;
  logic core_tx_load, core_rx_pop, asleep, wake_irq, rx_pin;
  modem_in_t modem_pins;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int loads = 0;
  int wakes = 0;
  int pops = 0;

  uart_pm_core DUT (.clk(clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write_strobe_n(wr_n), .bus_read_strobe_n(rd_n), .chip_select_n(cs_n),
    .bus_rdata(bus_rdata), .bus_rdata_oe(bus_rdata_oe), .power_save_pin(power_save_pin),
    .rx_pin(rx_pin), .modem_pins(modem_pins), .tx_pin(tx_pin), .request_to_send_n(rts_n),
    .terminal_ready_n(dtr_n), .oscillator_output_pin(osc), .core_tx_serial(core_tx_serial),
    .core_rx_data(8'h3c), .core_line_status(8'h60), .core_rx_level(8'h27),
    .core_int_pending(core_int_pending), .core_fifos_empty(core_fifos_empty),
    .core_rx_serial(core_rx_serial), .core_tx_data(core_tx_data), .core_tx_load(core_tx_load),
    .core_rx_pop(core_rx_pop), .asleep(asleep), .wake_irq(wake_irq));
  remote_uart rmt (.clk(clk), .rx_pin(rx_pin), .modem_pins(modem_pins));

  initial forever #10 clk = !clk;

  // Pulse tally and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    loads <= loads + int'(core_tx_load);
    wakes <= wakes + int'(wake_irq);
    pops <= pops + int'(core_rx_pop);
    if (cyc > 20000) begin
      fails++;
      end_sim;
    end
  end

  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask

  task end_sim;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Strobes held 5 clk: sync needs 3 edges
  task acc(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    bus_addr = a;
    bus_wdata = d;
    cs_n = 1'b0;
    wr_n = !w;
    rd_n = w;
    repeat (5) @(negedge clk);
    q = bus_rdata;
    wr_n = 1'b1;
    rd_n = 1'b1;
    cs_n = 1'b1;
    repeat (5) @(negedge clk);
  endtask

  task wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask

  task rd(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk("rdata", q, e);
  endtask

  task wait_st(input logic e);
    for (int i = 0; i < 40 && asleep !== e; i++) @(negedge clk);
    chk("asleep", asleep, e);
  endtask

  task t_regs;
    chk("tx", tx_pin, 1'b1);
    rd(ADDR_IER, REG_RESET);
    rd(ADDR_ISR, 8'hc1);
    core_int_pending = 1'b1;
    rd(ADDR_ISR, 8'hc0);
    core_int_pending = 1'b0;
    rd(ADDR_DATA, 8'h3c);
    chk("pops", 8'(pops), 8'h01);
    wr(ADDR_DATA, 8'h96);
    chk("txdata", core_tx_data, 8'h96);
    wr(ADDR_SPR, 8'ha5);
    rd(ADDR_SPR, 8'ha5);
    wr(ADDR_LCR, 8'h80);
    rd(ADDR_DATA, REVISION_CODE);
    rd(ADDR_IER, IDENT_CODE);
    wr(ADDR_DATA, 8'h01);
    rd(ADDR_DATA, 8'h01);
    wr(ADDR_LCR, LCR_ENH_KEY);
    wr(ADDR_IER, 8'h40);
    rd(ADDR_IER, 8'h40);
    wr(ADDR_LCR, 8'h03);
    rd(ADDR_SPR, 8'h27);
  endtask

  // Wake sources: tally stays 0 on start bit before wake enable, counts the load wake; modem wake seen on asleep
  task t_sleep;
    wr(ADDR_IER, 8'h10);
    wait_st(1'b1);
    chk("osc", osc, 1'b0);
    rmt.start_bit();
    chk("wakes", 8'(wakes), 8'h00);
    wait_st(1'b1);
    wr(ADDR_ISR, 8'h08);
    wr(ADDR_DATA, 8'h55);
    chk("wakes", 8'(wakes), 8'h01);
    wait_st(1'b1);
    rmt.toggle();
    repeat (10) @(negedge clk);
    chk("asleep", asleep, 1'b0);
    core_int_pending = 1'b1;
    wr(ADDR_MSR, 8'h00);
    rd(ADDR_MSR, 8'h11);
    repeat (10) @(negedge clk);
    chk("asleep", asleep, 1'b0);
    core_int_pending = 1'b0;
    wait_st(1'b1);
  endtask

  task t_save;
    int l0;
    int w0;
    power_save_pin = 1'b1;
    repeat (5) @(negedge clk);
    l0 = loads;
    w0 = wakes;
    wr(ADDR_DATA, 8'h77);
    chk("loads", 8'(loads - l0), 8'h00);
    chk("asleep", asleep, 1'b1);
    rmt.start_bit();
    chk("wakes", 8'(wakes - w0), 8'h01);
    wait_st(1'b1);
    power_save_pin = 1'b0;
    repeat (5) @(negedge clk);
    wr(ADDR_DATA, 8'h78);
    chk("loads", 8'(loads - l0), 8'h01);
    wr(ADDR_IER, 8'h00);
    repeat (10) @(negedge clk);
    chk("asleep", asleep, 1'b0);
  endtask

  task t_loop;
    wr(ADDR_MCR, 8'h03);
    chk("rts", rts_n, 1'b0);
    wr(ADDR_MCR, 8'h13);
    chk("rts", rts_n, 1'b1);
    chk("dtr", dtr_n, 1'b1);
    core_tx_serial = 1'b0;
    repeat (3) @(negedge clk);
    chk("tx", tx_pin, 1'b1);
    chk("rxser", core_rx_serial, 1'b0);
    rmt.toggle();
    rd(ADDR_MSR, 8'h32);
    rd(ADDR_MSR, 8'h30);
    wr(ADDR_MCR, 8'h00);
    chk("rxser", core_rx_serial, 1'b1);
    core_tx_serial = 1'b1;
  endtask

  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    t_regs;
    t_sleep;
    t_save;
    t_loop;
    end_sim;
  end
endmodule

`default_nettype wire
